// *** uvsf_defs.svh ***
/* Constants of the undervoltage, soft-start and filter gain register bank.
   Assumes one 50 MHz core clock shared with the APB master. */
`ifndef UVSF_DEFS_SVH
`define UVSF_DEFS_SVH
`define UVSF_CLK_HZ 50000000.0
`define UVSF_AW 18
`define UVSF_A(i) {16'(i), 2'b00}
`define UVSF_IDX_UVB 16'hfe29
`define UVSF_IDX_SSA 16'hfe2a
`define UVSF_IDX_SSB 16'hfe2b
`define UVSF_IDX_LFGA 16'hfe2c
`define UVSF_IDX_CTRL 16'hfe40
`define UVSF_IDX_STAT 16'hfe41
`define UVSF_IDX_ICLR 16'hfe42
`define UVSF_IDX_IEN 16'hfe43
`define UVSF_IDX_LIVE 16'hfe44
`define UVSF_CFG_RST 8'h00
`define UVSF_DEB_BIT 7
`define UVSF_THR_HI 6
`define UVSF_DEB_MS 100.0
`define UVSF_DEB_W 23
`define UVSF_SS_T0_MS 1.75
`define UVSF_SS_T1_MS 10.5
`define UVSF_SS_T2_MS 21.0
`define UVSF_SS_T3_MS 40.2
`define UVSF_REF_W 12
`define UVSF_REF_TGT 12'haaa
`define UVSF_STEP_W 16
`define UVSF_CTL_NRM 2
`define UVSF_EV_UV 0
`define UVSF_EV_RA 1
`define UVSF_EV_W 3
`endif

// *** uvsf_pkg.sv ***
/* Types of the undervoltage, soft-start and filter gain register bank.
   Assumes uvsf_defs.svh on the include path. */
`default_nettype none
`include "uvsf_defs.svh"
package uvsf_pkg;
  typedef enum logic [2:0] {
    UVSF_R_IDLE = 3'b001,
    UVSF_R_RUN = 3'b010,
    UVSF_R_DONE = 3'b100
  } uvsf_rstate_t;
  typedef logic [`UVSF_REF_W-1:0] uvsf_ref_t;
  typedef logic [`UVSF_STEP_W-1:0] uvsf_step_t;
endpackage : uvsf_pkg
`default_nettype wire

// *** uvsf_ramp_if.sv ***
/* Link between the register bank and one soft-start ramp generator.
   Assumes both ends run on core_clk. */
`timescale 1ns/1ps
`default_nettype none
interface uvsf_ramp_if;
  logic start;
  uvsf_pkg::uvsf_step_t stepPer;
  uvsf_pkg::uvsf_ref_t refVal;
  logic busy;
  logic done;
  modport ctl (output start, output stepPer, input refVal, input busy,
    input done);
  modport ramp (input start, input stepPer, output refVal, output busy,
    output done);
endinterface : uvsf_ramp_if
`default_nettype wire

// *** uvsf_uv_check.sv ***
/* Channel B undervoltage comparator with optional debounce.
   Assumes the sensed voltage comes from logic on core_clk. */
`timescale 1ns/1ps
`default_nettype none
`include "uvsf_defs.svh"
module uvsf_uv_check #(
  parameter int DEB_CYC = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] cfg,
  input wire logic [7:0] sense,
  output logic flag
);
  localparam logic [`UVSF_DEB_W-1:0] DEB_LAST = `UVSF_DEB_W'(DEB_CYC - 1);
  logic [`UVSF_THR_HI:0] thr;
  logic debSel;
  logic below;
  logic [`UVSF_DEB_W-1:0] cnt_ff;
  logic flag_ff;

  assign thr = cfg[`UVSF_THR_HI:0];
  assign debSel = cfg[`UVSF_DEB_BIT];
  // Threshold step is twice the sensed-bit step, so thr is compared with sense[7:1]
  assign below = (thr != 7'h00) && (thr > sense[7:1]);
  assign flag = flag_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (!below) begin
      cnt_ff <= '0;
    end else if (cnt_ff != DEB_LAST) begin
      cnt_ff <= cnt_ff + `UVSF_DEB_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= below && (!debSel || cnt_ff == DEB_LAST);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_uv_zero_thr: assert property (thr == 7'h00 |=> !flag)
    else $error("flag set with zero threshold");
  a_uv_fast_set: assert property (!debSel && below |=> flag)
    else $error("flag late without debounce");
  a_uv_drop_clr: assert property (!below |=> !flag)
    else $error("flag kept after comparison dropped");
  a_uv_deb_wait: assert property (
    debSel && !flag && cnt_ff != DEB_LAST |=> !flag)
    else $error("flag set before debounce time");
  c_uv_deb_set: cover property (debSel && $rose(flag));
endmodule : uvsf_uv_check
`default_nettype wire

// *** uvsf_ramp.sv ***
/* Soft-start reference ramp of one channel.
   Assumes a step period from the register bank, latched at start. */
`timescale 1ns/1ps
`default_nettype none
`include "uvsf_defs.svh"
module uvsf_ramp (
  input wire logic core_clk,
  input wire logic rst,
  uvsf_ramp_if.ramp rif
);
  uvsf_pkg::uvsf_rstate_t state_ff;
  uvsf_pkg::uvsf_rstate_t nxt_state;
  uvsf_pkg::uvsf_step_t per_ff;
  uvsf_pkg::uvsf_step_t stepCnt_ff;
  uvsf_pkg::uvsf_ref_t ref_ff;
  logic done_ff;
  logic stepEnd;
  logic lastStep;

  assign stepEnd = (state_ff == uvsf_pkg::UVSF_R_RUN)
    && (stepCnt_ff == `UVSF_STEP_W'(per_ff - `UVSF_STEP_W'(1)));
  // Ramp ends at two thirds of full_scale_span
  assign lastStep = stepEnd
    && (ref_ff == `UVSF_REF_W'(`UVSF_REF_TGT - `UVSF_REF_W'(1)));
  assign rif.refVal = ref_ff;
  assign rif.busy = (state_ff == uvsf_pkg::UVSF_R_RUN);
  assign rif.done = done_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      uvsf_pkg::UVSF_R_IDLE: begin
        if (rif.start) nxt_state = uvsf_pkg::UVSF_R_RUN;
      end
      uvsf_pkg::UVSF_R_RUN: begin
        if (rif.start) nxt_state = uvsf_pkg::UVSF_R_RUN;
        else if (lastStep) nxt_state = uvsf_pkg::UVSF_R_DONE;
      end
      uvsf_pkg::UVSF_R_DONE: begin
        if (rif.start) nxt_state = uvsf_pkg::UVSF_R_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= uvsf_pkg::UVSF_R_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_ff <= `UVSF_STEP_W'(1);
    end else if (rif.start) begin
      per_ff <= rif.stepPer;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stepCnt_ff <= '0;
    end else if (rif.start || stepEnd) begin
      stepCnt_ff <= '0;
    end else if (state_ff == uvsf_pkg::UVSF_R_RUN) begin
      stepCnt_ff <= stepCnt_ff + `UVSF_STEP_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_ff <= '0;
    end else if (rif.start) begin
      ref_ff <= '0;
    end else if (stepEnd) begin
      ref_ff <= ref_ff + `UVSF_REF_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= lastStep && !rif.start;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_ramp_done_tgt: assert property (rif.done |-> ref_ff == `UVSF_REF_TGT)
    else $error("ramp done away from two thirds of full scale");
  a_ramp_step_gap: assert property (
    $changed(ref_ff) && !$past(rif.start) |->
    $past(stepCnt_ff) == `UVSF_STEP_W'($past(per_ff) - `UVSF_STEP_W'(1)))
    else $error("ramp stepped off its period");
endmodule : uvsf_ramp
`default_nettype wire

// *** uvsf_top.sv ***
/* APB register bank for the channel B undervoltage check, the channel A and
   B soft-start ramps and the channel A normal-mode low-frequency gain.
   Assumes the APB master and the sensed-voltage source run on core_clk. */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uvsf_defs.svh"
module uvsf_top #(
  parameter int DEB_CYC = int'(`UVSF_DEB_MS * `UVSF_CLK_HZ / 1000.0),
  parameter int SS_CYC0 = int'(`UVSF_SS_T0_MS * `UVSF_CLK_HZ / 1000.0),
  parameter int SS_CYC1 = int'(`UVSF_SS_T1_MS * `UVSF_CLK_HZ / 1000.0),
  parameter int SS_CYC2 = int'(`UVSF_SS_T2_MS * `UVSF_CLK_HZ / 1000.0),
  parameter int SS_CYC3 = int'(`UVSF_SS_T3_MS * `UVSF_CLK_HZ / 1000.0)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`UVSF_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] sensedVoltageChanB,
  output logic undervoltFlagChanB,
  output logic [`UVSF_REF_W-1:0] rampRefA,
  output logic [`UVSF_REF_W-1:0] rampRefB,
  output logic [7:0] lfGainA,
  output logic lfGainActiveA,
  output logic irq
);
  localparam int TGT = int'(`UVSF_REF_TGT);
  localparam uvsf_pkg::uvsf_step_t STEP0 =
    (SS_CYC0 < TGT) ? `UVSF_STEP_W'(1) : `UVSF_STEP_W'(SS_CYC0 / TGT);
  localparam uvsf_pkg::uvsf_step_t STEP1 =
    (SS_CYC1 < TGT) ? `UVSF_STEP_W'(1) : `UVSF_STEP_W'(SS_CYC1 / TGT);
  localparam uvsf_pkg::uvsf_step_t STEP2 =
    (SS_CYC2 < TGT) ? `UVSF_STEP_W'(1) : `UVSF_STEP_W'(SS_CYC2 / TGT);
  localparam uvsf_pkg::uvsf_step_t STEP3 =
    (SS_CYC3 < TGT) ? `UVSF_STEP_W'(1) : `UVSF_STEP_W'(SS_CYC3 / TGT);

  logic [7:0] uvCfgB_ff;
  logic [7:0] ssRamp_ff [2];
  logic [7:0] lfGainReg_ff;
  logic [7:0] ctrl_ff;
  logic [`UVSF_EV_W-1:0] intStat_ff;
  logic [`UVSF_EV_W-1:0] intEn_ff;
  logic [`UVSF_EV_W-1:0] events;
  logic [`UVSF_EV_W-1:0] clrMask;
  logic [1:0] start_ff;
  logic [31:0] prdata_ff;
  logic [7:0] gainOut_ff;
  logic gainAct_ff;
  logic uvPrev_ff;
  logic uvFlag;
  logic setup;
  logic acc;
  logic wrEn;
  logic hit;
  logic [7:0] rdMux;

  uvsf_ramp_if rif[2] ();

  // Ramp step period for a 2-bit ramp time code
  function automatic uvsf_pkg::uvsf_step_t stepOf(input logic [1:0] sel);
    uvsf_pkg::uvsf_step_t per;
    per = STEP0;
    unique case (sel)
      2'b00: per = STEP0;
      2'b01: per = STEP1;
      2'b10: per = STEP2;
      2'b11: per = STEP3;
    endcase
    return per;
  endfunction : stepOf

  // APB decode, zero wait states
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wrEn = acc && pwrite && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = prdata_ff;

  always_comb begin
    hit = 1'b1;
    rdMux = 8'h00;
    unique case (paddr)
      `UVSF_A(`UVSF_IDX_UVB): rdMux = uvCfgB_ff;
      `UVSF_A(`UVSF_IDX_SSA): rdMux = ssRamp_ff[0];
      `UVSF_A(`UVSF_IDX_SSB): rdMux = ssRamp_ff[1];
      `UVSF_A(`UVSF_IDX_LFGA): rdMux = lfGainReg_ff;
      `UVSF_A(`UVSF_IDX_CTRL): rdMux = ctrl_ff;
      `UVSF_A(`UVSF_IDX_STAT): rdMux = {5'h00, intStat_ff};
      `UVSF_A(`UVSF_IDX_ICLR): rdMux = 8'h00;
      `UVSF_A(`UVSF_IDX_IEN): rdMux = {5'h00, intEn_ff};
      `UVSF_A(`UVSF_IDX_LIVE): rdMux = {5'h00, rif[1].busy, rif[0].busy,
        uvFlag};
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_ff <= {24'h00_0000, rdMux};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      uvCfgB_ff <= `UVSF_CFG_RST;
    end else if (wrEn && paddr == `UVSF_A(`UVSF_IDX_UVB)) begin
      uvCfgB_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lfGainReg_ff <= `UVSF_CFG_RST;
    end else if (wrEn && paddr == `UVSF_A(`UVSF_IDX_LFGA)) begin
      lfGainReg_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `UVSF_CFG_RST;
    end else if (wrEn && paddr == `UVSF_A(`UVSF_IDX_CTRL)) begin
      ctrl_ff <= {5'h00, pwdata[`UVSF_CTL_NRM], 2'b00};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intEn_ff <= '0;
    end else if (wrEn && paddr == `UVSF_A(`UVSF_IDX_IEN)) begin
      intEn_ff <= pwdata[`UVSF_EV_W-1:0];
    end
  end

  // Soft-start channels A and B
  for (genvar g = 0; g < 2; g++) begin : g_ch
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        ssRamp_ff[g] <= `UVSF_CFG_RST;
      end else if (wrEn && paddr == `UVSF_A(`UVSF_IDX_SSA + g)) begin
        ssRamp_ff[g] <= pwdata[7:0];
      end
    end

    // Writing a one to control bit g restarts ramp g
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        start_ff[g] <= 1'b0;
      end else begin
        start_ff[g] <= wrEn && paddr == `UVSF_A(`UVSF_IDX_CTRL) && pwdata[g];
      end
    end

    assign rif[g].start = start_ff[g];
    assign rif[g].stepPer = stepOf(ssRamp_ff[g][1:0]);

    uvsf_ramp u_ramp (
      .core_clk(core_clk),
      .rst(rst),
      .rif(rif[g].ramp)
    );
  end

  assign rampRefA = rif[0].refVal;
  assign rampRefB = rif[1].refVal;

  uvsf_uv_check #(
    .DEB_CYC(DEB_CYC)
  ) u_uv (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(uvCfgB_ff),
    .sense(sensedVoltageChanB),
    .flag(uvFlag)
  );

  assign undervoltFlagChanB = uvFlag;

  // Gain reaches the filter only in normal mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gainOut_ff <= 8'h00;
      gainAct_ff <= 1'b0;
    end else begin
      gainAct_ff <= ctrl_ff[`UVSF_CTL_NRM];
      gainOut_ff <= ctrl_ff[`UVSF_CTL_NRM] ? lfGainReg_ff : 8'h00;
    end
  end

  assign lfGainA = gainOut_ff;
  assign lfGainActiveA = gainAct_ff;

  // Sticky events, a new event wins over a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      uvPrev_ff <= 1'b0;
    end else begin
      uvPrev_ff <= uvFlag;
    end
  end

  assign events = {rif[1].done, rif[0].done, uvFlag && !uvPrev_ff};
  assign clrMask = (wrEn && paddr == `UVSF_A(`UVSF_IDX_ICLR))
    ? pwdata[`UVSF_EV_W-1:0] : '0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intStat_ff <= '0;
    end else begin
      intStat_ff <= (intStat_ff & ~clrMask) | events;
    end
  end

  assign irq = |(intStat_ff & intEn_ff);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_ssa_code_step: assert property (
    rif[0].start && ssRamp_ff[0][1:0] == 2'b01 |-> rif[0].stepPer == STEP1)
    else $error("channel A ramp code 01 gave wrong step");
  a_ssb_code_step: assert property (
    rif[1].start && ssRamp_ff[1][1:0] == 2'b11 |-> rif[1].stepPer == STEP3)
    else $error("channel B ramp code 11 gave wrong step");
  a_gain_light_off: assert property (
    !ctrl_ff[`UVSF_CTL_NRM] |=> !lfGainActiveA && lfGainA == 8'h00)
    else $error("gain applied outside normal mode");
  a_gain_normal_pass: assert property (
    ctrl_ff[`UVSF_CTL_NRM] |=> lfGainA == $past(lfGainReg_ff))
    else $error("normal mode gain not passed");
  a_uv_event_sticky: assert property (
    uvFlag && !uvPrev_ff |=> intStat_ff[`UVSF_EV_UV] [*2])
    else $error("undervoltage event lost");
  a_irq_level: assert property (
    intStat_ff[`UVSF_EV_RA] && intEn_ff[`UVSF_EV_RA] |-> irq)
    else $error("enabled event did not raise interrupt");

  c_ramp_a_done: cover property (rif[0].done);
  c_irq_rise: cover property ($rose(irq));
  c_bad_addr: cover property (pslverr);
endmodule : uvsf_top
`default_nettype wire

// *** testbench.sv ***
/* Self-checking bench for the undervoltage, soft-start and gain bank.
   Assumes uvsf_top and its includes; APB master and sense driven here. */
`timescale 1ns/1ps
`default_nettype none
`include "uvsf_defs.svh"
module testbench;
  localparam int DEB = 20;
  typedef struct {
    int sel;
    logic [31:0] exp;
    logic err;
  } uvsf_note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [17:0] paddr = 18'h00000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] sense = 8'hff;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic uvFlag;
  logic [11:0] refA;
  logic [11:0] refB;
  logic [7:0] gainA;
  logic gainOnA;
  logic irq;
  logic probe = 1'b0;
  int num_errors = 0;
  int checked = 0;
  uvsf_note_t notes[$];
  uvsf_note_t n;
  logic [31:0] obs;
  logic [7:0] g;
  int c;

  always #10 core_clk = ~core_clk;

  uvsf_top #(.DEB_CYC(DEB), .SS_CYC0(2730), .SS_CYC1(5460),
    .SS_CYC2(8190), .SS_CYC3(10920)) uut (
    .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensedVoltageChanB(sense), .undervoltFlagChanB(uvFlag),
    .rampRefA(refA), .rampRefB(refB), .lfGainA(gainA),
    .lfGainActiveA(gainOnA), .irq(irq));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] o);
    checked++;
    if (o !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, o);
    end
  endtask : chk

  // Takes the oldest note whenever a transfer or a probe completes
  always @(posedge core_clk) begin
    if ((psel & penable & pready) === 1'b1 || probe) begin
      if (notes.size() == 0) begin
        chk("note count", 32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        case (n.sel)
          0: obs = pwrite ? n.exp : prdata;
          1: obs = {31'h0, uvFlag};
          2: obs = {20'h0, refA};
          3: obs = {20'h0, refB};
          4: obs = {24'h0, gainA};
          5: obs = {31'h0, gainOnA};
          6: obs = {31'h0, irq};
          7: obs = {31'h0, refA === 12'haaa};
          default: obs = {31'h0, refB === 12'haaa};
        endcase
        chk($sformatf("output %0d", n.sel), n.exp, obs);
        if (n.sel == 0) begin
          chk("pslverr", {31'h0, n.err}, {31'h0, pslverr});
        end
      end
    end
  end

  task apb(input logic w, input logic [17:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [31:0] e, input logic er);
    notes.push_back('{0, e, er});
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [15:0] i, input logic [31:0] d);
    apb(1'b1, `UVSF_A(i), d, 4'hf, 32'h0, 1'b0);
  endtask : wr

  task rd(input logic [15:0] i, input logic [31:0] e);
    apb(1'b0, `UVSF_A(i), 32'h0, 4'hf, e, 1'b0);
  endtask : rd

  task pr(input int s, input logic [31:0] e);
    notes.push_back('{s, e, 1'b0});
    @(posedge core_clk);
    probe <= 1'b1;
    @(posedge core_clk);
    probe <= 1'b0;
  endtask : pr

  task idle(input int k);
    repeat (k) @(posedge core_clk);
  endtask : idle

  task ramp(input int ch, input int code);
    wr(ch ? `UVSF_IDX_SSB : `UVSF_IDX_SSA, code);
    wr(`UVSF_IDX_CTRL, ch ? 32'h2 : 32'h1);
    idle(2730 * (code + 1) - code - 7);
    pr(7 + ch, 0);
    idle(2 * code + 10);
    pr(7 + ch, 1);
    idle(5);
    pr(2 + ch, 12'haaa);
  endtask : ramp

  task uv(input logic [6:0] t, input logic [7:0] s);
    @(posedge core_clk);
    sense <= s;
    wr(`UVSF_IDX_UVB, {1'b0, t});
    idle(2);
    pr(1, t != 0 && t > s[7:1]);
  endtask : uv

  task close_out;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  initial begin
    void'($urandom(29061));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 16'hfe29; i <= 16'hfe2c; i++) rd(i, 0);
    for (int i = 16'hfe40; i <= 16'hfe44; i++) rd(i, 0);
    apb(1'b0, `UVSF_A(16'hfe30), 0, 4'hf, 0, 1'b1);
    apb(1'b0, `UVSF_A(16'hfe2a) | 18'h1, 0, 4'hf, 0, 1'b1);
    apb(1'b1, `UVSF_A(16'hfe2d), 32'h5a, 4'hf, 0, 1'b1);
    for (int i = 16'hfe2a; i <= 16'hfe2c; i++) begin
      g = 8'($urandom);
      wr(i, g);
      rd(i, g);
    end
    apb(1'b1, `UVSF_A(16'hfe2c), {24'h0, ~g}, 4'he, 0, 1'b0);
    rd(`UVSF_IDX_LFGA, g);
    wr(`UVSF_IDX_CTRL, 0);
    idle(2);
    pr(4, 0);
    pr(5, 0);
    wr(`UVSF_IDX_CTRL, 4);
    rd(`UVSF_IDX_CTRL, 4);
    pr(4, g);
    pr(5, 1);
    wr(`UVSF_IDX_ICLR, 7);
    wr(`UVSF_IDX_IEN, 2);
    ramp(0, 0);
    pr(6, 1);
    wr(`UVSF_IDX_IEN, 0);
    pr(6, 0);
    rd(`UVSF_IDX_STAT, 2);
    wr(`UVSF_IDX_IEN, 2);
    wr(`UVSF_IDX_ICLR, 2);
    pr(6, 0);
    rd(`UVSF_IDX_STAT, 0);
    for (int k = 1; k < 4; k++) ramp(0, k);
    ramp(1, $urandom % 4);
    rd(`UVSF_IDX_STAT, 6);
    uv(7'h00, 8'h00);
    uv(7'h40, 8'h7e);
    uv(7'h40, 8'h80);
    uv(7'h40, 8'h81);
    uv(7'h7f, 8'hfd);
    uv(7'h7f, 8'hfe);
    uv(7'h01, 8'h01);
    uv(7'h01, 8'h02);
    for (int k = 0; k < 8; k++) uv(7'($urandom), 8'($urandom));
    uv(7'h00, 8'h00);
    wr(`UVSF_IDX_ICLR, 7);
    wr(`UVSF_IDX_IEN, 1);
    @(posedge core_clk);
    sense <= 8'h00;
    wr(`UVSF_IDX_UVB, 32'h90);
    idle(DEB - 8);
    pr(1, 0);
    idle(10);
    pr(1, 1);
    pr(6, 1);
    rd(`UVSF_IDX_LIVE, 1);
    @(posedge core_clk);
    sense <= 8'hff;
    @(posedge core_clk);
    sense <= 8'h00;
    idle(2);
    pr(1, 0);
    idle(DEB - 8);
    pr(1, 0);
    idle(10);
    pr(1, 1);
    wr(`UVSF_IDX_ICLR, 1);
    pr(6, 0);
    rd(`UVSF_IDX_STAT, 0);
    idle(3);
    close_out();
  end
endmodule : testbench
`default_nettype wire
